// ===== core/oag_pkg.sv
/*
 Package for the operand address generator: modes, sizes, register-file
 layout and reset values. Assumes a 16-bit byte-addressed space.
*/
package oag_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int REG_BYTES = 256;
	localparam int REG_AW = 8;
	localparam logic [7:0] ZERO_WORD_OFFSET = 8'h00;
	localparam logic [7:0] STACK_POINTER_OFFSET = 8'h18;
	localparam logic [15:0] STACK_POINTER_RESET = 16'h0000;
	localparam logic [15:0] ZERO_VALUE = 16'h0000;
	localparam logic [15:0] BYTE_STEP = 16'h0001;
	localparam logic [15:0] WORD_STEP = 16'h0002;

	typedef enum logic [2:0] {
		MODE_REG_DIRECT = 3'h0,
		MODE_INDIRECT = 3'h1,
		MODE_INDIRECT_INC = 3'h2,
		MODE_IMMEDIATE = 3'h3,
		MODE_SHORT_INDEX = 3'h4,
		MODE_LONG_INDEX = 3'h5
	} mode_type;

	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h0,
		SIZE_WORD = 2'h1,
		SIZE_DWORD = 2'h2
	} size_type;

	typedef enum logic [1:0] {
		STACK_NONE = 2'h0,
		STACK_PUSH = 2'h1,
		STACK_POP = 2'h2
	} stack_op_type;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_READ_BASE = 5'b00010,
		ST_FORM = 5'b00100,
		ST_WRITE_BACK = 5'b01000,
		ST_DONE = 5'b10000
	} state_type;
endpackage

// ===== core/reg_file_mem.sv
/*
 Register file storage: 256 bytes, word-wide ports, two read ports with
 registered data and one write port with byte enables. Assumes word
 addresses are even; bit 0 of the address is ignored.
*/
`timescale 1ns/100ps
module reg_file_mem
	import oag_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// read port a
	input wire logic [7:0] rd_a_addr,
	output logic [15:0] rd_a_data,
	// read port b
	input wire logic [7:0] rd_b_addr,
	output logic [15:0] rd_b_data,
	// write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [1:0] wr_be,
	input wire logic [15:0] wr_data
);
	logic [7:0] mem_q [REG_BYTES];
	logic [15:0] rd_a_q;
	logic [15:0] rd_b_q;
	logic [7:0] wa;
	logic [7:0] ra;
	logic [7:0] rb;

	always_comb begin
		wa = {wr_addr[7:1], 1'b0};
		ra = {rd_a_addr[7:1], 1'b0};
		rb = {rd_b_addr[7:1], 1'b0};
	end

	// storage has no reset; only the read registers do
	always_ff @(posedge core_clk) begin
		if (wr_en && wr_be[0]) begin
			mem_q[wa] <= wr_data[7:0];
		end
		if (wr_en && wr_be[1]) begin
			mem_q[wa | 8'h01] <= wr_data[15:8];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_a_q <= 16'h0000;
			rd_b_q <= 16'h0000;
		end else begin
			rd_a_q <= {mem_q[ra | 8'h01], mem_q[ra]};
			rd_b_q <= {mem_q[rb | 8'h01], mem_q[rb]};
		end
	end

	assign rd_a_data = rd_a_q;
	assign rd_b_data = rd_b_q;
endmodule // reg_file_mem

// ===== core/ea_adder.sv
/*
 Effective-address adder: base plus short (sign-extended) or long
 displacement. Pure combinational.
*/
`timescale 1ns/100ps
module ea_adder
	import oag_pkg::*;
(
	// operands
	input wire logic [15:0] base,
	input wire logic [15:0] disp_long,
	input wire logic [7:0] disp_short,
	input wire logic use_short,
	// result
	output logic [15:0] sum
);
	logic [15:0] disp;

	always_comb begin
		disp = use_short ? {{8{disp_short[7]}}, disp_short} : disp_long;
		// carry out dropped: addresses wrap at 64K
		sum = 16'(base + disp);
	end
endmodule // ea_adder

// ===== core/operand_address_generator.sv
/*
 Operand address generator: decodes one operand reference per request
 into an effective address or immediate value, with pointer updates.
 Assumes the decoder issues one request at a time and waits for done;
 memory outside the register file is accessed by the caller.
*/
`timescale 1ns/100ps
module operand_address_generator
	import oag_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// instruction request
	input wire logic req_valid,
	input wire logic first_operand,
	input wire logic [2:0] mode,
	input wire logic [1:0] op_size,
	input wire logic [1:0] stack_op,
	input wire logic [7:0] reg_field,
	input wire logic [15:0] inst_field,
	output logic req_ready,
	// result
	output logic done,
	output logic [15:0] operand_addr,
	output logic [15:0] operand_value,
	output logic addr_is_reg,
	output logic value_valid,
	output logic align_error,
	output logic mode_error,
	// register-file direct access port
	input wire logic rf_wr_en,
	input wire logic [7:0] rf_wr_addr,
	input wire logic [1:0] rf_wr_be,
	input wire logic [15:0] rf_wr_data,
	input wire logic [7:0] rf_rd_addr,
	output logic [15:0] rf_rd_data,
	// stack pointer view
	output logic [15:0] stack_pointer
);
	logic rst_s1_q;
	logic rst_n_q;
	state_type state_q, state_d;
	logic [2:0] mode_q, mode_d;
	logic [1:0] size_q, size_d;
	logic [1:0] sop_q, sop_d;
	logic [7:0] reg_q, reg_d;
	logic [15:0] field_q, field_d;
	logic [15:0] addr_q, addr_d;
	logic [15:0] value_q, value_d;
	logic is_reg_q, is_reg_d;
	logic vvalid_q, vvalid_d;
	logic align_q, align_d;
	logic merr_q, merr_d;
	logic [15:0] sp_q, sp_d;
	logic special_q, special_d;
	logic upd_en;
	logic [7:0] upd_addr;
	logic [15:0] upd_data;
	logic mem_wr_en;
	logic [7:0] mem_wr_addr;
	logic [1:0] mem_wr_be;
	logic [15:0] mem_wr_data;
	logic [15:0] base_raw;
	logic [15:0] port_raw;
	logic [15:0] base_word;
	logic [7:0] rf_rd_q;
	logic [15:0] ea_sum;
	logic [15:0] step;
	logic [15:0] step_sum;
	logic [15:0] sp_minus;
	logic [15:0] sp_plus;

	// reset release through two flops
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_s1_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n_q <= rst_s1_q;
		end
	end

	// pointer write-back takes the write port over the outside writer
	always_comb begin
		mem_wr_en = upd_en | rf_wr_en;
		mem_wr_addr = upd_en ? upd_addr : rf_wr_addr;
		mem_wr_be = upd_en ? 2'b11 : rf_wr_be;
		mem_wr_data = upd_en ? upd_data : rf_wr_data;
	end

	reg_file_mem u_mem (
		.core_clk(core_clk),
		.rst_n(rst_n_q),
		.rd_a_addr(reg_q),
		.rd_a_data(base_raw),
		.rd_b_addr(rf_rd_addr),
		.rd_b_data(port_raw),
		.wr_en(mem_wr_en),
		.wr_addr(mem_wr_addr),
		.wr_be(mem_wr_be),
		.wr_data(mem_wr_data)
	);

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			rf_rd_q <= 8'h00;
			special_q <= 1'b0;
		end else begin
			rf_rd_q <= rf_rd_addr;
			special_q <= special_d;
		end
	end
	assign special_d = (reg_q[7:1] == ZERO_WORD_OFFSET[7:1]) ||
		(reg_q[7:1] == STACK_POINTER_OFFSET[7:1]);

	// zero word and stack pointer override the storage on reads
	always_comb begin
		if (rf_rd_q[7:1] == ZERO_WORD_OFFSET[7:1]) begin
			rf_rd_data = ZERO_VALUE;
		end else if (rf_rd_q[7:1] == STACK_POINTER_OFFSET[7:1]) begin
			rf_rd_data = sp_q;
		end else begin
			rf_rd_data = port_raw;
		end
		if (reg_q[7:1] == ZERO_WORD_OFFSET[7:1]) begin
			base_word = ZERO_VALUE;
		end else if (reg_q[7:1] == STACK_POINTER_OFFSET[7:1]) begin
			base_word = sp_q;
		end else begin
			base_word = base_raw;
		end
	end

	ea_adder u_add (
		.base(base_word),
		.disp_long(field_q),
		.disp_short(field_q[7:0]),
		.use_short(mode_q == MODE_SHORT_INDEX),
		.sum(ea_sum)
	);

	always_comb begin
		step = (size_q == SIZE_BYTE) ? BYTE_STEP : WORD_STEP;
		step_sum = 16'(base_word + step);
		sp_minus = 16'(sp_q - WORD_STEP);
		sp_plus = 16'(sp_q + WORD_STEP);
	end

	// one memory-class reference per instruction; direct ones unlimited
	logic mem_ref_q, mem_ref_d;
	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			mem_ref_q <= 1'b0;
		end else begin
			mem_ref_q <= mem_ref_d;
		end
	end

	always_comb begin
		state_d = state_q;
		mode_d = mode_q;
		size_d = size_q;
		sop_d = sop_q;
		reg_d = reg_q;
		field_d = field_q;
		addr_d = addr_q;
		value_d = value_q;
		is_reg_d = is_reg_q;
		vvalid_d = vvalid_q;
		align_d = align_q;
		merr_d = merr_q;
		sp_d = sp_q;
		mem_ref_d = mem_ref_q;
		upd_en = 1'b0;
		upd_addr = reg_q;
		upd_data = step_sum;
		if (rf_wr_en && rf_wr_addr[7:1] == STACK_POINTER_OFFSET[7:1]) begin
			if (rf_wr_be[0]) begin
				sp_d[7:0] = rf_wr_data[7:0];
			end
			if (rf_wr_be[1]) begin
				sp_d[15:8] = rf_wr_data[15:8];
			end
		end
		case (state_q)
			ST_IDLE: begin
				if (req_valid) begin
					mode_d = mode;
					size_d = op_size;
					sop_d = stack_op;
					reg_d = reg_field;
					field_d = inst_field;
					align_d = 1'b0;
					merr_d = 1'b0;
					vvalid_d = 1'b0;
					if (first_operand) begin
						mem_ref_d = 1'b0;
					end
					state_d = ST_READ_BASE;
				end
			end
			ST_READ_BASE: begin
				state_d = ST_FORM;
			end
			ST_FORM: begin
				state_d = ST_DONE;
				if (mode_q != MODE_REG_DIRECT) begin
					merr_d = mem_ref_q;
					mem_ref_d = 1'b1;
				end
				case (mode_q)
					MODE_REG_DIRECT: begin
						addr_d = {8'h00, reg_q};
						is_reg_d = 1'b1;
						value_d = base_word;
						vvalid_d = 1'b1;
						align_d = (size_q == SIZE_WORD && reg_q[0]) ||
							(size_q == SIZE_DWORD && reg_q[1:0] != 2'b00);
					end
					MODE_INDIRECT, MODE_INDIRECT_INC: begin
						addr_d = base_word;
						is_reg_d = (base_word[15:8] == 8'h00);
						align_d = (size_q == SIZE_WORD && base_word[0]) ||
							(size_q == SIZE_DWORD &&
							(base_word[1:0] != 2'b00 ||
							base_word[15:8] != 8'h00));
						if (mode_q == MODE_INDIRECT_INC) begin
							state_d = ST_WRITE_BACK;
						end
					end
					MODE_IMMEDIATE: begin
						is_reg_d = 1'b0;
						vvalid_d = 1'b1;
						addr_d = 16'h0000;
						value_d = (size_q == SIZE_BYTE) ?
							{8'h00, field_q[7:0]} : field_q;
					end
					MODE_SHORT_INDEX, MODE_LONG_INDEX: begin
						addr_d = ea_sum;
						is_reg_d = (ea_sum[15:8] == 8'h00);
						align_d = (size_q == SIZE_WORD && ea_sum[0]);
					end
					default: begin
						merr_d = 1'b1;
					end
				endcase
				if (sop_q == STACK_PUSH) begin
					sp_d = sp_minus;
				end else if (sop_q == STACK_POP) begin
					sp_d = sp_plus;
				end
			end
			ST_WRITE_BACK: begin
				if (reg_q[7:1] == STACK_POINTER_OFFSET[7:1]) begin
					sp_d = (sop_q == STACK_PUSH) ? 16'(sp_q + step) :
						16'(sp_q + step);
				end else if (!special_q) begin
					upd_en = 1'b1;
				end
				state_d = ST_DONE;
			end
			ST_DONE: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			state_q <= ST_IDLE;
			mode_q <= MODE_REG_DIRECT;
			size_q <= SIZE_BYTE;
			sop_q <= STACK_NONE;
			reg_q <= 8'h00;
			field_q <= 16'h0000;
			addr_q <= 16'h0000;
			value_q <= 16'h0000;
			is_reg_q <= 1'b0;
			vvalid_q <= 1'b0;
			align_q <= 1'b0;
			merr_q <= 1'b0;
			sp_q <= STACK_POINTER_RESET;
		end else begin
			state_q <= state_d;
			mode_q <= mode_d;
			size_q <= size_d;
			sop_q <= sop_d;
			reg_q <= reg_d;
			field_q <= field_d;
			addr_q <= addr_d;
			value_q <= value_d;
			is_reg_q <= is_reg_d;
			vvalid_q <= vvalid_d;
			align_q <= align_d;
			merr_q <= merr_d;
			sp_q <= sp_d;
		end
	end

	assign req_ready = (state_q == ST_IDLE);
	assign done = (state_q == ST_DONE);
	assign operand_addr = addr_q;
	assign operand_value = value_q;
	assign addr_is_reg = is_reg_q;
	assign value_valid = vvalid_q;
	assign align_error = align_q;
	assign mode_error = merr_q;
	assign stack_pointer = sp_q;
endmodule // operand_address_generator

// ===== tb/oag_asserts.sv
/*
 Port checker for the operand address generator.
 Assumes one core clock and the top-level active-low reset.
*/
`timescale 1ns/100ps
module oag_asserts
	import oag_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// request
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic [2:0] mode,
	input wire logic [1:0] op_size,
	input wire logic [1:0] stack_op,
	input wire logic [7:0] reg_field,
	input wire logic [15:0] inst_field,
	// result
	input wire logic done,
	input wire logic [15:0] operand_addr,
	input wire logic [15:0] operand_value,
	input wire logic value_valid,
	input wire logic align_error,
	// register file view
	input wire logic rf_wr_en,
	input wire logic [7:0] rf_rd_addr,
	input wire logic [15:0] rf_rd_data,
	input wire logic [15:0] stack_pointer
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	sequence take_s;
		req_valid && req_ready;
	endsequence
	sequence quiet_s;
		!done ##1 !done;
	endsequence
	done_time_a: assert property (take_s ##0 mode != 3'h2 |-> ##1 quiet_s ##1 done) else $error("done late or early");
	inc_time_a: assert property (take_s ##0 mode == 3'h2 |-> ##1 quiet_s ##1 !done ##1 done) else $error("inc done timing");
	zero_read_a: assert property (rf_rd_addr[7:1] == 7'h00 |=> rf_rd_data == 16'h0000) else $error("zero word nonzero");
	sp_view_a: assert property (rf_rd_addr == 8'h18 && !rf_wr_en |=> rf_rd_data == $past(stack_pointer)) else $error("sp view wrong");
	push_step_a: assert property (take_s ##0 stack_op == 2'h1 && mode != 3'h2 |-> ##3 stack_pointer == $past(stack_pointer, 3) - 16'h0002) else $error("push step wrong");
	pop_step_a: assert property (take_s ##0 stack_op == 2'h2 && mode != 3'h2 |-> ##3 stack_pointer == $past(stack_pointer, 3) + 16'h0002) else $error("pop step wrong");
	imm_byte_a: assert property (take_s ##0 mode == 3'h3 && op_size == 2'h0 |-> ##3 value_valid && operand_value == ($past(inst_field, 3) & 16'h00FF)) else $error("immediate byte wrong");
	zero_base_a: assert property (take_s ##0 mode == 3'h5 && reg_field == 8'h00 |-> ##3 operand_addr == $past(inst_field, 3)) else $error("zero base address wrong");
	word_align_a: assert property (take_s ##0 mode == 3'h0 && op_size == 2'h1 && reg_field[0] |-> ##3 align_error) else $error("odd word not flagged");
endmodule // oag_asserts

bind operand_address_generator oag_asserts u_asserts (.core_clk, .reset_n,
	.req_valid, .req_ready, .mode, .op_size, .stack_op, .reg_field,
	.inst_field, .done, .operand_addr, .operand_value, .value_valid,
	.align_error, .rf_wr_en, .rf_rd_addr, .rf_rd_data, .stack_pointer);

// ===== tb/oag_inst_src.sv
/*
 Instruction-stream model: turns a packed command into one held request.
 Assumes go is a one-cycle pulse and requests are taken on req_ready.
*/
`timescale 1ns/100ps
module oag_inst_src (
	// clock and command
	input wire logic core_clk,
	input wire logic go,
	input wire logic [31:0] cmd,
	input wire logic req_ready,
	// request
	output logic req_valid,
	output logic [31:0] fields
);
	initial req_valid = 1'b0;
	initial fields = 32'h0000_0000;
	always @(posedge core_clk) begin
		if (go) begin
			req_valid <= 1'b1;
			fields <= cmd;
		end else if (req_valid && req_ready) begin
			// released fields flip so a late sample never matches
			req_valid <= 1'b0;
			fields <= ~fields;
		end
	end
endmodule // oag_inst_src

// ===== tb/operand_address_generator_bench.sv
/*
 Self-checking bench for the operand address generator.
 Assumes the instruction-stream model and the bound port checker.
*/
`timescale 1ns/100ps
module operand_address_generator_bench;
	typedef struct packed {
		logic [31:0] c;
		logic [15:0] a;
		logic [15:0] v;
		logic [3:0] f;
	} row_type;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic go = 1'b0;
	logic [31:0] cmd = 32'h0000_0000;
	logic rf_wr_en = 1'b0;
	logic [7:0] rf_wr_addr = 8'h00;
	logic [15:0] rf_wr_data = 16'h0000;
	logic [7:0] rf_rd_addr = 8'h02;
	logic req_valid, req_ready, done, addr_is_reg, value_valid;
	logic align_error, mode_error;
	logic [31:0] fields;
	logic [15:0] operand_addr, operand_value, rf_rd_data, stack_pointer;
	logic [2:0] sec [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
	row_type rows [14];
	int miscompares = 0;
	int checks_done = 0;

	always #10 core_clk = ~core_clk;

	oag_inst_src src (.core_clk(core_clk), .go(go), .cmd(cmd),
		.req_ready(req_ready), .req_valid(req_valid), .fields(fields));

	operand_address_generator dut (.core_clk(core_clk), .reset_n(reset_n),
		.req_valid(req_valid), .first_operand(fields[31]),
		.mode(fields[30:28]), .op_size(fields[27:26]),
		.stack_op(fields[25:24]), .reg_field(fields[23:16]),
		.inst_field(fields[15:0]), .req_ready(req_ready), .done(done),
		.operand_addr(operand_addr), .operand_value(operand_value),
		.addr_is_reg(addr_is_reg), .value_valid(value_valid),
		.align_error(align_error), .mode_error(mode_error),
		.rf_wr_en(rf_wr_en), .rf_wr_addr(rf_wr_addr), .rf_wr_be(2'h3),
		.rf_wr_data(rf_wr_data), .rf_rd_addr(rf_rd_addr),
		.rf_rd_data(rf_rd_data), .stack_pointer(stack_pointer));

	task automatic chk(input string n, input logic [15:0] e,
		input logic [15:0] s);
		checks_done++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// returns in the done cycle, while results are valid
	task automatic run(input logic [31:0] c);
		int i;
		@(posedge core_clk);
		cmd <= c;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (i = 0; i < 20; i++) begin
			@(negedge core_clk);
			if (done === 1'b1) break;
		end
		if (i == 20) begin
			miscompares++;
			$display("[FAIL] done expected 1 seen timeout");
			results;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		rf_wr_en <= 1'b1;
		rf_wr_addr <= a;
		rf_wr_data <= d;
		@(posedge core_clk);
		rf_wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge core_clk);
		rf_rd_addr <= a;
		@(posedge core_clk);
		@(negedge core_clk);
		chk("rf_rd_data", e, rf_rd_data);
	endtask

	initial begin
		rows = '{
			'{32'h8420_0000, 16'h0020, 16'h1000, 4'hC},
			'{32'hB000_12AB, 16'h0000, 16'h00AB, 4'h4},
			'{32'hB400_12AB, 16'h0000, 16'h12AB, 4'h4},
			'{32'h9420_0000, 16'h1000, 16'h0000, 4'h8},
			'{32'hC420_0080, 16'h0F80, 16'h0000, 4'h8},
			'{32'hC020_007F, 16'h107F, 16'h0000, 4'h8},
			'{32'hD420_F000, 16'h0000, 16'h0000, 4'h8},
			'{32'hD400_1234, 16'h1234, 16'h0000, 4'h8},
			'{32'h9418_0000, 16'h0200, 16'h0000, 4'h8},
			'{32'hC418_0002, 16'h0202, 16'h0000, 4'h8},
			'{32'h8421_0000, 16'h0000, 16'h0000, 4'h2},
			'{32'h8822_0000, 16'h0000, 16'h0000, 4'h2},
			'{32'hE420_0000, 16'h0000, 16'h0000, 4'h1},
			'{32'h9424_0000, 16'h0000, 16'h0000, 4'h2}};
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		@(negedge core_clk);
		chk("req_ready", 16'h0001, {15'h0, req_ready});
		chk("stack_pointer", 16'h0000, stack_pointer);
		wr(8'h20, 16'h1000);
		wr(8'h24, 16'h1001);
		wr(8'h18, 16'h0200);
		for (int k = 0; k < 14; k++) begin
			run(rows[k].c);
			if (rows[k].f[3]) chk("operand_addr", rows[k].a, operand_addr);
			if (rows[k].f[2]) chk("operand_value", rows[k].v, operand_value);
			chk("error flags", {14'h0, rows[k].f[1:0]},
				{14'h0, align_error, mode_error});
			if (rows[k].f[1:0] == 2'h0)
				chk("value_valid", {15'h0, rows[k].f[2]}, {15'h0, value_valid});
		end
		// zero word must read zero even after a write
		wr(8'h00, 16'hFFFF);
		rd(8'h00, 16'h0000);
		rd(8'h18, 16'h0200);
		run(32'hA420_0000);
		chk("inc addr", 16'h1000, operand_addr);
		chk("addr_is_reg", 16'h0000, {15'h0, addr_is_reg});
		rd(8'h20, 16'h1002);
		run(32'hA020_0000);
		rd(8'h20, 16'h1003);
		run(32'h8520_0000);
		chk("push sp", 16'h01FE, stack_pointer);
		chk("addr_is_reg", 16'h0001, {15'h0, addr_is_reg});
		run(32'h8620_0000);
		chk("pop sp", 16'h0200, stack_pointer);
		foreach (sec[j]) begin
			run(32'h9420_0000);
			run({1'b0, sec[j], 28'h420_0002});
			chk("second ref", {15'h0, sec[j] != 3'h0}, {15'h0, mode_error});
		end
		// reset in mid-run: pointer must fall back, storage may stay
		@(posedge core_clk);
		reset_n <= 1'b0;
		@(negedge core_clk);
		chk("reset sp", 16'h0000, stack_pointer);
		@(posedge core_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		run(32'hD400_1234);
		chk("addr after reset", 16'h1234, operand_addr);
		rd(8'h18, 16'h0000);
		results;
	end
endmodule // operand_address_generator_bench
